// file: src/dlic_pkg.sv
// shared constants and types of the die link initiator configuration block
package dlic_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] DLIC_IDX_CTL0 = 8'hd8;
  localparam logic [7:0] DLIC_IDX_CTL1 = 8'hd9;
  localparam logic [7:0] DLIC_IDX_STAT = 8'hda;
  localparam int         DLIC_ADDR_W   = 12;
  localparam int         DLIC_DATA_W   = 32;

  // reset values
  localparam logic [7:0] DLIC_CTL0_RST = 8'h00;
  localparam logic [7:0] DLIC_CTL1_RST = 8'h00;
  localparam logic [7:0] DLIC_STAT_RST = 8'h00;

  // data line groups
  localparam int         DLIC_LINES    = 8;
  localparam logic [7:0] DLIC_MASK_LO  = 8'h0f;
  localparam logic [7:0] DLIC_MASK_ALL = 8'hff;

  // clock divider encodings
  typedef enum logic [1:0] {
    DLIC_DIV1,
    DLIC_DIV2,
    DLIC_DIV3,
    DLIC_DIV4
  } dlic_div_t;

  // primary control register layout
  typedef struct packed {
    logic      initiatorEnable;
    logic      connectionWidth;
    logic      stopClockInWait;
    logic [2:0] reserved;
    dlic_div_t linkClockDivider;
  } dlic_ctl0_t;

  // secondary control register layout
  typedef struct packed {
    logic       targetIrqEnable;
    logic [2:0] reserved;
    logic [3:0] ackTimeoutCycles;
  } dlic_ctl1_t;

  // link error status register layout
  typedef struct packed {
    logic       errorSummaryFlag;
    logic       ackLineErrorFlag;
    logic       cancelFlag;
    logic       timeoutErrorFlag;
    logic       transactionErrorFlag;
    logic       parityErrorFlag;
    logic [1:0] receivedParity;
  } dlic_stat_t;

  // error events reported by the transaction engine
  typedef struct packed {
    logic       ackLineError;
    logic       cancel;
    logic       transactionError;
    logic       parityError;
    logic [1:0] parity;
  } dlic_evt_t;

endpackage : dlic_pkg

// file: src/dlic_top.sv
// configuration, status and link clock logic of the die link initiator
// Contract
// - enable bit writable once in normal mode, freely in special mode
// - while disabled, no link pin is driven; pins stay general purpose
// - once enabled, active data lines idle low and link clock is divided
// - width 0 uses the low four lines, width 1 all eight lines
// - width bit write-once in normal mode, free in special mode
// - stop-in-wait always writable; set stops the link clock during wait
// - divider field selects bus clock divided by 1, 2, 3 or 4
// - divider field write-once in normal mode, free in special mode
// - link clock high phase never longer than half its period
// - after enable is set in normal mode, writes to write-once fields are ignored
// - while enabled, irq enable passes the target interrupt line, clear blocks it
// - timeout field counts link clocks waiting for ack, then flags timeout
// - timeout field write-once in normal mode, free in special mode
// - setting zero: acknowledge expected in the cycle right after transfer
// - nonzero setting: timeout only after that many wait states pass
// - status layout summary, ack, cancel, timeout, trans, parity, two parity
// - writing one to summary clears all error flags; zero does nothing
// - link clock low when disabled, stopped, or waiting with stop set
// - enabled data lines acting as inputs get pull-downs
`timescale 1ns/1ps

module dlic_top
  import dlic_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  input  wire logic [DLIC_ADDR_W-1:0] avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [DLIC_DATA_W-1:0] avs_writedata,
  input  wire logic [3:0]             avs_byteenable,
  output logic      [DLIC_DATA_W-1:0] avs_readdata,
  output logic                        avs_waitrequest,
  input  wire logic                   specialModePin,
  input  wire logic                   cpuWait,
  input  wire logic                   cpuStop,
  input  wire logic                   txActive,
  input  wire logic [DLIC_LINES-1:0]  txData,
  input  wire logic [DLIC_LINES-1:0]  txDriveEn,
  input  wire logic                   ackWaitStart,
  input  wire logic                   ackSeen,
  input  wire dlic_evt_t              errEvent,
  input  wire logic                   target_irq_line,
  output logic                        link_clock,
  output logic      [DLIC_LINES-1:0]  link_data_lines_o,
  output logic      [DLIC_LINES-1:0]  link_data_lines_oe,
  output logic      [DLIC_LINES-1:0]  linkPullDownEn,
  output logic                        linkPinsOwned,
  output logic                        targetIrqToCpu,
  output logic                        errorIrqToCpu,
  output logic                        linkClockTick
);

  // register state
  dlic_ctl0_t ctl0_q;
  dlic_ctl1_t ctl1_q;
  dlic_stat_t stat_q;
  dlic_stat_t stat_d;
  logic       ack_q;
  logic [DLIC_DATA_W-1:0] rdData_q;

  // synchronisers for pins
  logic specMeta_q;
  logic specSync_q;
  logic irqMeta_q;
  logic irqSync_q;

  // link clock generator
  logic [1:0] divCnt_q;
  logic [1:0] divCnt_d;
  logic       clkHigh_q;
  logic       clkHigh_d;
  logic       divOneRun_q;

  // acknowledge timeout counter
  logic       ackWait_q;
  logic [3:0] waitCnt_q;

  // avalon decode
  logic        busReq;
  logic        hitCtl0;
  logic        hitCtl1;
  logic        hitStat;
  logic        wrCommit;
  logic        wrLowByte;
  logic [7:0]  wrByte;
  logic [7:0]  rdByte;
  logic        writeOnceLocked;
  logic        wrCtl0;
  logic        wrCtl1;
  logic        wrStat;
  logic        clearErrors;

  // link control decode
  logic        enabled;
  logic        clockRun;
  logic        clockActive;
  logic [1:0]  divTop;
  logic [1:0]  divHalf;
  logic        divIsOne;
  logic        divReload;
  logic        periodStart;
  logic        timeoutHit;
  logic        anyError;
  logic [7:0]  lineMask;

  // two flip-flop synchronisers for asynchronous pins
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      specMeta_q <= 1'b0;
      specSync_q <= 1'b0;
      irqMeta_q  <= 1'b0;
      irqSync_q  <= 1'b0;
    end else begin
      specMeta_q <= specialModePin;
      specSync_q <= specMeta_q;
      irqMeta_q  <= target_irq_line;
      irqSync_q  <= irqMeta_q;
    end
  end

  // bus decode; one wait cycle, then the answer
  assign busReq          = avs_read | avs_write;
  assign hitCtl0         = avs_address == {2'b00, DLIC_IDX_CTL0, 2'b00};
  assign hitCtl1         = avs_address == {2'b00, DLIC_IDX_CTL1, 2'b00};
  assign hitStat         = avs_address == {2'b00, DLIC_IDX_STAT, 2'b00};
  assign avs_waitrequest = busReq & ~ack_q;
  assign wrCommit        = avs_write & ack_q;
  assign wrLowByte       = wrCommit & avs_byteenable[0];
  assign wrByte          = avs_writedata[7:0];
  assign wrCtl0          = wrLowByte & hitCtl0;
  assign wrCtl1          = wrLowByte & hitCtl1;
  assign wrStat          = wrLowByte & hitStat;
  assign writeOnceLocked = ctl0_q.initiatorEnable & ~specSync_q;
  assign clearErrors     = wrStat & wrByte[7];
  assign avs_readdata    = rdData_q;

  // read mux; reserved bits are held zero in the registers
  assign rdByte = hitCtl0 ? ctl0_q :
                  hitCtl1 ? ctl1_q :
                  hitStat ? stat_q : 8'h00;

  // acknowledge and read data capture
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ack_q    <= 1'b0;
      rdData_q <= '0;
    end else begin
      ack_q <= busReq & ~ack_q;
      if (avs_read & ~ack_q) begin
        rdData_q <= {{(DLIC_DATA_W-8){1'b0}}, rdByte};
      end
    end
  end

  // primary control register with write-once protection
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctl0_q <= DLIC_CTL0_RST;
    end else if (wrCtl0) begin
      ctl0_q.stopClockInWait <= wrByte[5];
      if (!writeOnceLocked) begin
        ctl0_q.initiatorEnable  <= wrByte[7];
        ctl0_q.connectionWidth  <= wrByte[6];
        ctl0_q.linkClockDivider <= dlic_div_t'(wrByte[1:0]);
      end
    end
  end

  // secondary control register with write-once timeout field
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctl1_q <= DLIC_CTL1_RST;
    end else if (wrCtl1) begin
      ctl1_q.targetIrqEnable <= wrByte[7];
      if (!writeOnceLocked) begin
        ctl1_q.ackTimeoutCycles <= wrByte[3:0];
      end
    end
  end

  // status flags: events set, summary write clears, set wins
  always_comb begin
    stat_d = stat_q;
    if (clearErrors) begin
      stat_d.errorSummaryFlag     = 1'b0;
      stat_d.ackLineErrorFlag     = 1'b0;
      stat_d.cancelFlag           = 1'b0;
      stat_d.timeoutErrorFlag     = 1'b0;
      stat_d.transactionErrorFlag = 1'b0;
      stat_d.parityErrorFlag      = 1'b0;
    end
    if (errEvent.ackLineError) begin
      stat_d.ackLineErrorFlag = 1'b1;
    end
    if (errEvent.cancel) begin
      stat_d.cancelFlag = 1'b1;
    end
    if (timeoutHit) begin
      stat_d.timeoutErrorFlag = 1'b1;
    end
    if (errEvent.transactionError) begin
      stat_d.transactionErrorFlag = 1'b1;
    end
    if (errEvent.parityError) begin
      stat_d.parityErrorFlag = 1'b1;
      stat_d.receivedParity  = errEvent.parity;
    end
    if (anyError) begin
      stat_d.errorSummaryFlag = 1'b1;
    end
  end

  assign anyError = errEvent.ackLineError | errEvent.cancel | timeoutHit |
                    errEvent.transactionError | errEvent.parityError;

  // status register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stat_q <= DLIC_STAT_RST;
    end else begin
      stat_q <= stat_d;
    end
  end

  // link clock control
  assign enabled     = ctl0_q.initiatorEnable;
  assign clockRun    = enabled & ~cpuStop & ~(cpuWait & ctl0_q.stopClockInWait);
  assign clockActive = clockRun | clkHigh_q;
  assign divTop      = ctl0_q.linkClockDivider;
  assign divHalf     = 2'(({1'b0, divTop} + 3'd1) >> 1);
  assign divIsOne    = ctl0_q.linkClockDivider == DLIC_DIV1;
  assign divReload   = wrCtl0 & ~writeOnceLocked; // restart the period; a new divider never stretches a high phase
  assign periodStart = clockRun & (divCnt_q == 2'd0);
  assign divCnt_d    = (!clockActive || divReload || divCnt_q == divTop) ? 2'd0 : divCnt_q + 2'd1;
  // high phase ends at floor(N/2), finishing a started high phase on stop
  assign clkHigh_d   = clockActive & ~divReload & ~divIsOne & (divCnt_d < divHalf);

  // divider counter and clock register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      divCnt_q    <= 2'd0;
      clkHigh_q   <= 1'b0;
      divOneRun_q <= 1'b0;
    end else begin
      divCnt_q    <= divCnt_d;
      clkHigh_q   <= clkHigh_d;
      divOneRun_q <= clockRun & divIsOne;
    end
  end

  // divide by one gates the bus clock itself
  assign link_clock    = divOneRun_q ? ref_clk : clkHigh_q;
  assign linkClockTick = periodStart;

  // acknowledge timeout counter, counted in link clock periods
  assign timeoutHit = ackWait_q & ~ackSeen & periodStart &
                      (waitCnt_q == ctl1_q.ackTimeoutCycles);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ackWait_q <= 1'b0;
      waitCnt_q <= 4'h0;
    end else if (ackWaitStart) begin
      ackWait_q <= 1'b1;
      waitCnt_q <= 4'h0;
    end else if (ackSeen || timeoutHit) begin
      ackWait_q <= 1'b0;
    end else if (ackWait_q && periodStart) begin
      waitCnt_q <= waitCnt_q + 4'h1;
    end
  end

  // data lines: idle low while enabled, engine drives during transfers
  assign lineMask           = ctl0_q.connectionWidth ? DLIC_MASK_ALL : DLIC_MASK_LO;
  assign linkPinsOwned      = enabled;
  assign link_data_lines_o  = (enabled & txActive) ? (txData & lineMask) : 8'h00;
  assign link_data_lines_oe = ~enabled ? 8'h00 :
                              txActive ? (txDriveEn & lineMask) : lineMask;
  assign linkPullDownEn     = enabled ? (lineMask & ~link_data_lines_oe) : 8'h00;

  // interrupt routing
  assign targetIrqToCpu = enabled & ctl1_q.targetIrqEnable & irqSync_q;
  assign errorIrqToCpu  = stat_q.errorSummaryFlag;

  // helper: length of the current high phase
  logic [2:0] highLen_q;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      highLen_q <= 3'd0;
    end else begin
      highLen_q <= clkHigh_q ? highLen_q + 3'd1 : 3'd0;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_en_once;
    (enabled && !specSync_q) |=> enabled;
  endproperty
  a_en_once: assert property (p_en_once) else $error("enable cleared in normal mode");

  property p_pins_free;
    !enabled |-> (link_data_lines_oe == 8'h00 && linkPullDownEn == 8'h00);
  endproperty
  a_pins_free: assert property (p_pins_free) else $error("link pins driven while disabled");

  property p_idle_low;
    (enabled && !txActive) |-> (link_data_lines_o == 8'h00 && link_data_lines_oe == lineMask);
  endproperty
  a_idle_low: assert property (p_idle_low) else $error("idle lines not driven low");

  property p_width;
    !ctl0_q.connectionWidth |-> (link_data_lines_oe[7:4] == 4'h0);
  endproperty
  a_width: assert property (p_width) else $error("upper lines used in four line mode");

  property p_lock;
    (writeOnceLocked && wrCtl0) |=> ($stable(ctl0_q.connectionWidth) && $stable(ctl0_q.linkClockDivider));
  endproperty
  a_lock: assert property (p_lock) else $error("write-once field changed after enable");

  property p_tmo_lock;
    (writeOnceLocked && wrCtl1) |=> $stable(ctl1_q.ackTimeoutCycles);
  endproperty
  a_tmo_lock: assert property (p_tmo_lock) else $error("timeout field changed after enable");

  property p_high_max;
    clkHigh_q |-> (highLen_q < {1'b0, divHalf});
  endproperty
  a_high_max: assert property (p_high_max) else $error("link clock high phase too long");

  property p_clk_stop;
    (!clockRun && !clkHigh_q) |=> !clkHigh_q && !divOneRun_q;
  endproperty
  a_clk_stop: assert property (p_clk_stop) else $error("link clock runs while stopped");

  property p_irq;
    targetIrqToCpu |-> (enabled && ctl1_q.targetIrqEnable && $past(target_irq_line, 2));
  endproperty
  a_irq: assert property (p_irq) else $error("target irq passed while blocked");

  property p_timeout;
    (ackWaitStart && !timeoutHit) |=> !stat_q.timeoutErrorFlag || $past(stat_q.timeoutErrorFlag, 1);
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout flagged at wait start");

  property p_clear;
    (clearErrors && !anyError) |=> (stat_q[7:2] == 6'h00);
  endproperty
  a_clear: assert property (p_clear) else $error("error flags not cleared");

  property p_summary;
    anyError |=> stat_q.errorSummaryFlag;
  endproperty
  a_summary: assert property (p_summary) else $error("summary flag missed an error");

endmodule : dlic_top

// file: verif/dlic_target_model.sv
// target die model: answers the acknowledge wait and raises the target interrupt
`timescale 1ns/1ps

module dlic_target_model
  import dlic_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       linkClockTick,
  input  wire logic       ackWaitStart,
  input  wire logic [4:0] ackDelay,
  input  wire logic       irqReq,
  output logic            ackSeen,
  output logic            target_irq_line
);
  logic       armed_q;
  logic [4:0] tickCnt_q;

  // count link clock periods after the last transfer, acknowledge after ackDelay of them
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      armed_q   <= 1'b0;
      tickCnt_q <= 5'h00;
      ackSeen   <= 1'b0;
    end else begin
      ackSeen <= 1'b0;
      if (ackWaitStart) begin
        armed_q   <= (ackDelay != 5'h00);
        tickCnt_q <= 5'h00;
        ackSeen   <= (ackDelay == 5'h00);  // no wait state at setting zero
      end else if (armed_q && linkClockTick) begin
        tickCnt_q <= tickCnt_q + 5'h01;
        if (tickCnt_q + 5'h01 == ackDelay) begin  // wait states within the allowance
          ackSeen <= 1'b1;
          armed_q <= 1'b0;
        end
      end
    end
  end

  // interrupt pin follows the request of the bench
  assign target_irq_line = irqReq;
endmodule : dlic_target_model

// file: verif/tb.sv
// self-checking bench of the die link initiator configuration block
`timescale 1ns/1ps

module tb
  import dlic_pkg::*;
;
  localparam logic [11:0] addrCtl0 = {2'b00, DLIC_IDX_CTL0, 2'b00};
  localparam logic [11:0] addrCtl1 = {2'b00, DLIC_IDX_CTL1, 2'b00};
  localparam logic [11:0] addrStat = {2'b00, DLIC_IDX_STAT, 2'b00};
  localparam logic [11:0] addrFree = 12'h36c;

  logic        refClk = 1'b0, rst = 1'b1, avsRead = 1'b0, avsWrite = 1'b0, avsWaitrequest;
  logic [11:0] avsAddress = 12'h000;
  logic [31:0] avsWritedata = 32'h0, avsReaddata;
  logic        specialModePin = 1'b0, cpuWait = 1'b0, cpuStop = 1'b0, txActive = 1'b0;
  logic [7:0]  txData = 8'ha5, txDriveEn = 8'h00, lineO, lineOe, pullDown;
  logic        ackWaitStart = 1'b0, ackSeen, targetIrqLine, irqReq = 1'b0;
  logic [4:0]  ackDelay = 5'h1f;
  dlic_evt_t   errEvent = '0;
  logic        linkClock, pinsOwned, irqToCpu, errIrq, linkTick;
  int          nFail = 0, checkCount = 0, cycles = 0;

  dlic_top dlic_top_i (.ref_clk(refClk), .rst(rst), .avs_address(avsAddress), .avs_read(avsRead),
    .avs_write(avsWrite), .avs_writedata(avsWritedata), .avs_byteenable(4'h1), .avs_readdata(avsReaddata),
    .avs_waitrequest(avsWaitrequest), .specialModePin(specialModePin), .cpuWait(cpuWait), .cpuStop(cpuStop),
    .txActive(txActive), .txData(txData), .txDriveEn(txDriveEn), .ackWaitStart(ackWaitStart),
    .ackSeen(ackSeen), .errEvent(errEvent), .target_irq_line(targetIrqLine), .link_clock(linkClock),
    .link_data_lines_o(lineO), .link_data_lines_oe(lineOe), .linkPullDownEn(pullDown),
    .linkPinsOwned(pinsOwned), .targetIrqToCpu(irqToCpu), .errorIrqToCpu(errIrq), .linkClockTick(linkTick));

  dlic_target_model dlic_target_model_i (.ref_clk(refClk), .rst(rst), .linkClockTick(linkTick),
    .ackWaitStart(ackWaitStart), .ackDelay(ackDelay), .irqReq(irqReq), .ackSeen(ackSeen),
    .target_irq_line(targetIrqLine));

  // 250 MHz bus clock and a ceiling on run length
  always #2 refClk = ~refClk;
  always @(posedge refClk) begin
    cycles++;
    if (cycles == 20000) begin
      nFail++;
      give_verdict();
    end
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checkCount, nFail);
    if (nFail == 0 && checkCount > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      nFail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // one Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] d, output logic [31:0] q);
    @(posedge refClk);
    avsRead      <= !wr;
    avsWrite     <= wr;
    avsAddress   <= a;
    avsWritedata <= {24'h0, d};
    // waitrequest and read data are taken at the rising edge itself
    do begin
      @(posedge refClk);
    end while (avsWaitrequest !== 1'b0);
    q = avsReaddata;
    avsRead  <= 1'b0;
    avsWrite <= 1'b0;
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q, {24'h0, exp});
  endtask : rd_chk

  task automatic wait_ticks(input int n);
    int c;
    c = 0;
    while (c < n) begin
      @(negedge refClk);
      if (linkTick === 1'b1) c++;
    end
  endtask : wait_ticks

  // high samples and period starts of the link clock over n bus cycles
  task automatic measure(input int n, output int hi, output int tk);
    hi = 0;
    tk = 0;
    repeat (n) begin
      @(negedge refClk);
      if (linkClock === 1'b1) hi++;
      if (linkTick === 1'b1) tk++;
    end
  endtask : measure

  task automatic t_reset;
    rd_chk(addrCtl0, DLIC_CTL0_RST);
    rd_chk(addrCtl1, DLIC_CTL1_RST);
    rd_chk(addrStat, DLIC_STAT_RST);
    wr(addrFree, 8'hff);
    rd_chk(addrFree, 8'h00);
    chk(lineOe, 8'h00);
    chk(pinsOwned, 1'b0);
    chk(linkClock, 1'b0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_write_once;
    wr(addrCtl1, 8'hf3);
    rd_chk(addrCtl1, 8'h83);
    wr(addrCtl0, 8'h81);  // four-line width in normal mode
    wr(addrCtl0, 8'h3e);
    rd_chk(addrCtl0, 8'ha1);
    wr(addrCtl1, 8'h0c);
    rd_chk(addrCtl1, 8'h03);
    @(negedge refClk);
    chk(pinsOwned, 1'b1);
    chk(lineOe, 8'h0f);
    chk(lineO & lineOe, 8'h00);
    @(posedge refClk);
    txActive  <= 1'b1;
    txDriveEn <= 8'hf3;
    @(negedge refClk);
    chk(lineOe, 8'h03);
    chk(pullDown, 8'h0c);
    chk(lineO & lineOe, 8'h01);
    @(posedge refClk);
    txActive <= 1'b0;
    $display("test write once done");
  endtask : t_write_once

  task automatic t_clock;
    int hi, tk;
    @(posedge refClk);
    specialModePin <= 1'b1;
    repeat (3) @(posedge refClk);
    for (int d = 0; d < 4; d++) begin
      wr(addrCtl0, {6'h20, 2'(d)});
      repeat (6) @(posedge refClk);
      measure(4 * (d + 1), hi, tk);
      chk(hi, 4 * ((d + 1) / 2));
      chk(tk, 4);
    end
    wr(addrCtl0, 8'hc1);
    @(negedge refClk);
    chk(lineOe, 8'hff);
    wr(addrCtl0, 8'h01);
    rd_chk(addrCtl0, 8'h01);
    chk(lineOe, 8'h00);
    measure(8, hi, tk);
    chk(hi, 0);
    $display("test clock done");
  endtask : t_clock

  task automatic t_stop_wait;
    int hi, tk;
    wr(addrCtl0, 8'h81);
    @(posedge refClk);
    cpuWait <= 1'b1;
    measure(8, hi, tk);
    chk(hi, 4);
    wr(addrCtl0, 8'ha1);
    repeat (4) @(posedge refClk);
    measure(8, hi, tk);
    chk(hi, 0);
    @(posedge refClk);
    cpuWait <= 1'b0;
    cpuStop <= 1'b1;
    wr(addrCtl0, 8'h81);
    repeat (4) @(posedge refClk);
    measure(8, hi, tk);
    chk(hi, 0);
    @(posedge refClk);
    cpuStop <= 1'b0;
    repeat (4) @(posedge refClk);
    measure(8, hi, tk);
    chk(hi, 4);
    $display("test stop wait done");
  endtask : t_stop_wait

  // acknowledge wait with setting t; the target answers within it or only after 31 link clock periods
  task automatic t_timeout(input logic [3:0] t, input logic ack);
    wr(addrCtl1, {4'h0, t});
    wait_ticks(1);
    @(posedge refClk);
    ackDelay     <= ack ? {1'b0, t} : 5'h1f;
    ackWaitStart <= 1'b1;
    @(posedge refClk);
    ackWaitStart <= 1'b0;
    if (t != 4'h0) begin
      wait_ticks(int'(t));
      @(negedge refClk);
      chk(errIrq, 1'b0);
    end
    wait_ticks(3);
    chk(errIrq, !ack);
    rd_chk(addrStat, ack ? 8'h00 : 8'h90);
    wr(addrStat, 8'h00);
    rd_chk(addrStat, ack ? 8'h00 : 8'h90);
    wr(addrStat, 8'h80);
    rd_chk(addrStat, 8'h00);
    $display("test timeout done");
  endtask : t_timeout

  task automatic t_events_irq;
    @(posedge refClk);
    errEvent <= dlic_evt_t'(6'h3f);
    @(posedge refClk);
    errEvent <= dlic_evt_t'(6'h00);
    rd_chk(addrStat, 8'hef);
    wr(addrStat, 8'h80);
    rd_chk(addrStat, 8'h03);
    wr(addrCtl1, 8'h80);
    @(posedge refClk);
    irqReq <= 1'b1;
    repeat (4) @(posedge refClk);
    @(negedge refClk);
    chk(irqToCpu, 1'b1);
    wr(addrCtl1, 8'h00);
    @(negedge refClk);
    chk(irqToCpu, 1'b0);
    $display("test events and interrupt done");
  endtask : t_events_irq

  // reset for four cycles, then the scenarios in order
  initial begin
    repeat (4) @(posedge refClk);
    rst <= 1'b0;
    t_reset();
    t_write_once();
    t_clock();
    t_stop_wait();
    t_timeout(4'h0, 1'b0);
    t_timeout(4'h0, 1'b1);
    t_timeout(4'h3, 1'b0);
    t_timeout(4'hf, 1'b0);
    t_timeout(4'h3, 1'b1);
    t_timeout(4'hf, 1'b1);
    t_events_irq();
    give_verdict();
  end
endmodule : tb
